// ---- core/ttpu_regs.vh ----
`ifndef TTPU_REGS_VH
`define TTPU_REGS_VH

// Counter width
`define TTPU_CNT_W 16
// Timer input pins idle high through their pull-ups
`define TTPU_PIN_IDLE 1'b1
// Service slot counter: four slots per service round
`define TTPU_SLOT_W 2
`define TTPU_SLOT_LAST 2'h3
`define TTPU_SLOT_PIN0 2'h0
`define TTPU_SLOT_PIN1 2'h1
`define TTPU_SLOT_INT 2'h2
// Count and limit reset values
`define TTPU_CNT_RST 16'h0000
`define TTPU_MAX_RST 16'hffff
// Mode encoding of a pin timer
`define TTPU_MODE_W 2
`define TTPU_MODE_OFF 2'h0
`define TTPU_MODE_CONT 2'h1
`define TTPU_MODE_SINGLE 2'h2
// Clock source of a pin timer
`define TTPU_SRC_INTERNAL 1'b0
`define TTPU_SRC_PRESCALE 1'b1
// Timing: CPU clock figures
`define TTPU_CPU_MHZ 40
`define TTPU_XTAL_MHZ 10
`define TTPU_XTAL_MULT 4
`define TTPU_MAX_RESP_CYC 6
// Slow clock divider in power save
`define TTPU_SAVE_DIV_W 4
`define TTPU_SAVE_DIV 4'h7

`endif

// ---- core/ttpu_sync.v ----
`timescale 1ns/1ps
`include "ttpu_regs.vh"
module ttpu_sync (
    // Clock and reset
    input wire mclk_in,
    input wire reset_in,
    // Async level in, synced level and rising edge out
    input wire async_in,
    output wire level_out,
    output wire rise_out
);
    reg meta_ff;
    reg sync_ff;
    reg last_ff;

    // First stage read only by the second
    always @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            // Idle level, so no false edge follows reset
            meta_ff <= `TTPU_PIN_IDLE;
            sync_ff <= `TTPU_PIN_IDLE;
            last_ff <= `TTPU_PIN_IDLE;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign level_out = sync_ff;
    assign rise_out = sync_ff & ~last_ff;
endmodule // ttpu_sync

// ---- core/ttpu_timer.v ----
`timescale 1ns/1ps
`include "ttpu_regs.vh"
module ttpu_timer #(
    parameter CNT_W = `TTPU_CNT_W
) (
    // Clock and reset
    input wire mclk_in,
    input wire reset_in,
    // Service and count qualifiers
    input wire service_in,
    input wire tick_in,
    input wire enable_in,
    input wire single_in,
    input wire alt_in,
    input wire restart_in,
    // Limits
    input wire [CNT_W-1:0] max_a_in,
    input wire [CNT_W-1:0] max_b_in,
    // State
    output reg [CNT_W-1:0] count_out,
    output reg use_b_out,
    output reg done_out,
    output reg period_end_out
);
    wire [CNT_W-1:0] limit;
    wire hit;

    assign limit = use_b_out ? max_b_in : max_a_in;
    assign hit = (count_out == limit);

    always @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            count_out <= `TTPU_CNT_RST;
            use_b_out <= 1'b0;
            done_out <= 1'b0;
            period_end_out <= 1'b0;
        end else begin
            period_end_out <= 1'b0;
            if (restart_in) begin
                count_out <= `TTPU_CNT_RST;
                use_b_out <= 1'b0;
                done_out <= 1'b0;
            end else if (service_in && tick_in && enable_in &&
                         !done_out) begin
                if (hit) begin
                    // Wrap to zero; swap limits when alternating
                    count_out <= `TTPU_CNT_RST;
                    period_end_out <= 1'b1;
                    if (alt_in)
                        use_b_out <= ~use_b_out;
                    // Single shot stops after the full sequence
                    if (single_in && (!alt_in || use_b_out))
                        done_out <= 1'b1;
                end else begin
                    count_out <= count_out + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // ttpu_timer

// ---- core/ttpu_top.v ----
`timescale 1ns/1ps
`include "ttpu_regs.vh"
module ttpu_top #(
    parameter CNT_W = `TTPU_CNT_W
) (
    // Clock and reset
    input wire mclk_in,
    input wire reset_in,
    // Power save control
    input wire power_save_in,
    input wire irq_event_in,
    // First pin timer configuration
    input wire [`TTPU_MODE_W-1:0] first_mode_in,
    input wire first_alt_in,
    input wire first_ext_clk_in,
    input wire first_src_in,
    input wire first_gate_en_in,
    input wire [CNT_W-1:0] first_max_a_in,
    input wire [CNT_W-1:0] first_max_b_in,
    // Second pin timer configuration
    input wire [`TTPU_MODE_W-1:0] second_mode_in,
    input wire second_alt_in,
    input wire second_ext_clk_in,
    input wire second_src_in,
    input wire second_gate_en_in,
    input wire [CNT_W-1:0] second_max_a_in,
    input wire [CNT_W-1:0] second_max_b_in,
    // Internal prescale timer configuration
    input wire prescale_en_in,
    input wire [CNT_W-1:0] prescale_max_in,
    // Restart strobes, one per timer
    input wire first_restart_in,
    input wire second_restart_in,
    input wire prescale_restart_in,
    // Timer pins
    input wire first_pin_timer_in,
    input wire second_pin_timer_in,
    output reg first_pin_timer_out,
    output reg second_pin_timer_out,
    // Internal results
    output reg prescale_tick_out,
    output reg dma_request_out,
    output reg slow_clock_out,
    output reg [CNT_W-1:0] first_count_out,
    output reg [CNT_W-1:0] second_count_out,
    output reg [CNT_W-1:0] prescale_count_out
);
    // Service slot, one-hot power states
    localparam ST_FULL = 2'b01;
    localparam ST_SLOW = 2'b10;
    // Derived rates kept for reference of the time base
    localparam CPU_MHZ = `TTPU_XTAL_MHZ * `TTPU_XTAL_MULT;
    localparam MAX_RATE_MHZ = CPU_MHZ / 4;

    reg [1:0] pstate_ff;
    reg [1:0] nxt_pstate;
    reg [`TTPU_SLOT_W-1:0] slot_ff;
    reg [`TTPU_SAVE_DIV_W-1:0] div_ff;
    reg step_ff;

    wire in0_lvl;
    wire in0_rise;
    wire in1_lvl;
    wire in1_rise;
    wire [CNT_W-1:0] c0;
    wire [CNT_W-1:0] c1;
    wire [CNT_W-1:0] c2;
    wire b0;
    wire b1;
    wire d0;
    wire d1;
    wire e0;
    wire e1;
    wire e2;
    wire unused_b2;
    wire unused_d2;
    wire e2_end;

    // Slot decode, shared by the three services
    function slot_is;
        input [`TTPU_SLOT_W-1:0] slot;
        input [`TTPU_SLOT_W-1:0] want;
        begin
            slot_is = (slot == want);
        end
    endfunction

    // Mode decode: off refuses counting
    function mode_runs;
        input [`TTPU_MODE_W-1:0] mode;
        begin
            mode_runs = (mode != `TTPU_MODE_OFF);
        end
    endfunction

    // Single shot stops after its last period
    function mode_single;
        input [`TTPU_MODE_W-1:0] mode;
        begin
            mode_single = (mode == `TTPU_MODE_SINGLE);
        end
    endfunction

    // Pin inputs pass two flops before use
    ttpu_sync u_sync0 (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .async_in(first_pin_timer_in),
        .level_out(in0_lvl),
        .rise_out(in0_rise)
    );
    ttpu_sync u_sync1 (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .async_in(second_pin_timer_in),
        .level_out(in1_lvl),
        .rise_out(in1_rise)
    );

    // Power state: any interrupt returns to full rate
    always @* begin
        nxt_pstate = pstate_ff;
        case (pstate_ff)
            ST_FULL: begin
                if (power_save_in && !irq_event_in)
                    nxt_pstate = ST_SLOW;
            end
            ST_SLOW: begin
                if (irq_event_in || !power_save_in)
                    nxt_pstate = ST_FULL;
            end
            default: begin
                nxt_pstate = ST_FULL;
            end
        endcase
    end

    // Slow clock keeps timers running, only less often
    always @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            pstate_ff <= ST_FULL;
            div_ff <= {`TTPU_SAVE_DIV_W{1'b0}};
            step_ff <= 1'b1;
        end else begin
            pstate_ff <= nxt_pstate;
            if (nxt_pstate == ST_SLOW) begin
                if (div_ff == `TTPU_SAVE_DIV) begin
                    div_ff <= {`TTPU_SAVE_DIV_W{1'b0}};
                    step_ff <= 1'b1;
                end else begin
                    div_ff <= div_ff + {{(`TTPU_SAVE_DIV_W-1){1'b0}}, 1'b1};
                    step_ff <= 1'b0;
                end
            end else begin
                div_ff <= {`TTPU_SAVE_DIV_W{1'b0}};
                step_ff <= 1'b1;
            end
        end
    end

    // Round-robin slot advances on each enabled step
    always @(posedge mclk_in or posedge reset_in) begin
        if (reset_in)
            slot_ff <= {`TTPU_SLOT_W{1'b0}};
        else if (step_ff)
            slot_ff <= slot_ff + {{(`TTPU_SLOT_W-1){1'b0}}, 1'b1};
    end

    // Count enables: mode and optional gate; clock source goes to the tick
    assign e0 = mode_runs(first_mode_in) &&
                (!first_gate_en_in || in0_lvl);
    assign e1 = mode_runs(second_mode_in) &&
                (!second_gate_en_in || in1_lvl);
    assign e2 = prescale_en_in;

    // Latch external rising edges until the timer's slot
    // A fresh edge counts at once when its slot is due
    reg pend0_ff;
    reg pend1_ff;
    wire svc0;
    wire svc1;
    wire svc2;
    wire tick0;
    wire tick1;
    assign svc0 = step_ff && slot_is(slot_ff, `TTPU_SLOT_PIN0);
    assign svc1 = step_ff && slot_is(slot_ff, `TTPU_SLOT_PIN1);
    assign svc2 = step_ff && slot_is(slot_ff, `TTPU_SLOT_INT);

    always @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            pend0_ff <= 1'b0;
            pend1_ff <= 1'b0;
        end else begin
            // Older edge is consumed first, a new one stays pending
            if (svc0)
                pend0_ff <= pend0_ff & in0_rise;
            else
                pend0_ff <= pend0_ff | in0_rise;
            if (svc1)
                pend1_ff <= pend1_ff & in1_rise;
            else
                pend1_ff <= pend1_ff | in1_rise;
        end
    end

    // Source select: pin clock, prescaler, or every service
    assign tick0 = first_ext_clk_in ? (pend0_ff | in0_rise) :
                   (first_src_in == `TTPU_SRC_PRESCALE) ?
                   prescale_tick_out : 1'b1;
    assign tick1 = second_ext_clk_in ? (pend1_ff | in1_rise) :
                   (second_src_in == `TTPU_SRC_PRESCALE) ?
                   prescale_tick_out : 1'b1;

    // Three counters of the same kind
    ttpu_timer #(.CNT_W(CNT_W)) u_first (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .service_in(svc0),
        .tick_in(tick0),
        .enable_in(e0),
        .single_in(mode_single(first_mode_in)),
        .alt_in(first_alt_in),
        .restart_in(first_restart_in),
        .max_a_in(first_max_a_in),
        .max_b_in(first_max_b_in),
        .count_out(c0),
        .use_b_out(b0),
        .done_out(d0),
        .period_end_out()
    );
    ttpu_timer #(.CNT_W(CNT_W)) u_second (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .service_in(svc1),
        .tick_in(tick1),
        .enable_in(e1),
        .single_in(mode_single(second_mode_in)),
        .alt_in(second_alt_in),
        .restart_in(second_restart_in),
        .max_a_in(second_max_a_in),
        .max_b_in(second_max_b_in),
        .count_out(c1),
        .use_b_out(b1),
        .done_out(d1),
        .period_end_out()
    );
    // Internal timer: one limit, no alternation, no pins
    ttpu_timer #(.CNT_W(CNT_W)) u_prescale (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .service_in(svc2),
        .tick_in(1'b1),
        .enable_in(e2),
        .single_in(1'b0),
        .alt_in(1'b0),
        .restart_in(prescale_restart_in),
        .max_a_in(prescale_max_in),
        .max_b_in(prescale_max_in),
        .count_out(c2),
        .use_b_out(unused_b2),
        .done_out(unused_d2),
        .period_end_out(e2_end)
    );

    // Pin outputs: high on primary, low on secondary period
    // Edge to pin at full rate: two sync flops, up to three cycles slot wait, timer and output flops, up to seven cycles
    always @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            first_pin_timer_out <= 1'b1;
            second_pin_timer_out <= 1'b1;
            prescale_tick_out <= 1'b0;
            dma_request_out <= 1'b0;
            slow_clock_out <= 1'b0;
            first_count_out <= `TTPU_CNT_RST;
            second_count_out <= `TTPU_CNT_RST;
            prescale_count_out <= `TTPU_CNT_RST;
        end else begin
            first_pin_timer_out <= first_alt_in ? ~b0 : ~d0;
            second_pin_timer_out <= second_alt_in ? ~b1 : ~d1;
            // Prescale tick held until the pin timers have been served
            if (e2_end)
                prescale_tick_out <= 1'b1;
            else if (svc1)
                prescale_tick_out <= 1'b0;
            dma_request_out <= e2_end;
            slow_clock_out <= (pstate_ff == ST_SLOW);
            first_count_out <= c0;
            second_count_out <= c1;
            prescale_count_out <= c2;
        end
    end
endmodule // ttpu_top

// ---- bench/ttpu_chk.sv ----
`timescale 1ns/1ps
`include "ttpu_regs.vh"
module ttpu_chk #(
    parameter CNT_W = 16
) (
    // Clock and reset
    input wire mclk_in,
    input wire reset_in,
    // Watched inputs
    input wire irq_event_in,
    input wire [`TTPU_MODE_W-1:0] first_mode_in,
    input wire first_alt_in,
    input wire first_ext_clk_in,
    input wire [CNT_W-1:0] first_max_a_in,
    input wire first_pin_timer_in,
    // Watched outputs
    input wire first_pin_timer_out,
    input wire second_pin_timer_out,
    input wire dma_request_out,
    input wire slow_clock_out,
    input wire [CNT_W-1:0] first_count_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);
    a_four_slot: assert property ($changed(first_count_out) |=>
        $stable(first_count_out) [*3]) else $error("count moved twice");
    a_count_limit: assert property (!first_alt_in |->
        first_count_out <= first_max_a_in) else $error("count over limit");
    a_count_step: assert property ($changed(first_count_out) |->
        first_count_out == $past(first_count_out) + 16'h1 ||
        first_count_out == 16'h0) else $error("count jumped");
    a_wrap_limit: assert property ($changed(first_count_out) &&
        first_count_out == 16'h0 && !first_alt_in |->
        $past(first_count_out) == first_max_a_in) else $error("early wrap");
    a_pin_alt: assert property ($changed(first_count_out) &&
        first_count_out == 16'h0 && first_alt_in &&
        first_mode_in == `TTPU_MODE_CONT |->
        ##[0:6] $changed(first_pin_timer_out)) else $error("pin stuck");
    a_dma_pulse: assert property (dma_request_out |=>
        !dma_request_out [*3]) else $error("dma pulse too long");
    a_irq_wake: assert property (irq_event_in |->
        ##[1:2] !slow_clock_out) else $error("slow clock kept");
    a_save_rate: assert property (slow_clock_out &&
        $past(slow_clock_out) && $changed(first_count_out) |=>
        $stable(first_count_out) [*8]) else $error("save rate too fast");
    a_ext_react: assert property ($rose(first_pin_timer_in) &&
        first_ext_clk_in && first_mode_in == `TTPU_MODE_CONT &&
        !slow_clock_out |-> ##[1:7] $changed(first_count_out))
        else $error("edge not counted");
    a_reset_pins: assert property ($fell(reset_in) |->
        first_pin_timer_out && second_pin_timer_out)
        else $error("pins low at reset");
    c_dma: cover property (dma_request_out);
    c_alt: cover property (first_alt_in && $fell(first_pin_timer_out));
    c_wake: cover property (slow_clock_out ##1 !slow_clock_out);
endmodule // ttpu_chk
bind ttpu_top ttpu_chk #(.CNT_W(CNT_W)) ttpu_chk_inst (
    .mclk_in(mclk_in), .reset_in(reset_in), .irq_event_in(irq_event_in),
    .first_mode_in(first_mode_in), .first_alt_in(first_alt_in),
    .first_ext_clk_in(first_ext_clk_in), .first_max_a_in(first_max_a_in),
    .first_pin_timer_in(first_pin_timer_in),
    .first_pin_timer_out(first_pin_timer_out),
    .second_pin_timer_out(second_pin_timer_out),
    .dma_request_out(dma_request_out), .slow_clock_out(slow_clock_out),
    .first_count_out(first_count_out));

// ---- bench/ttpu_event_src.sv ----
`timescale 1ns/1ps
module ttpu_event_src (
    // Clock
    input wire mclk_in,
    // Start strobe, rising edges to make
    input wire start_in,
    input wire [7:0] pulses_in,
    // Event pin, pulled up when idle
    output reg pin_out
);
    reg [7:0] left_ff = 8'h00;
    reg [1:0] ph_ff = 2'h0;
    initial pin_out = 1'b1;
    // Four low, four high: never faster than a service round
    always @(posedge mclk_in) begin
        #1;
        if (start_in) begin
            left_ff = pulses_in;
            ph_ff = 2'h0;
            pin_out = 1'b0;
        end else if (left_ff != 8'h00) begin
            ph_ff = ph_ff + 2'h1;
            if (ph_ff == 2'h0) begin
                pin_out = !pin_out;
                if (pin_out)
                    left_ff = left_ff - 8'h01;
            end
        end
    end
endmodule // ttpu_event_src

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`include "ttpu_regs.vh"
module tb_top;
    reg mclk_in = 1'b0;
    reg reset_in = 1'b1;
    reg ps = 1'b0, irq = 1'b0, a1 = 1'b0, e1 = 1'b0, s1 = 1'b0;
    reg a2 = 1'b0, e2 = 1'b0, pe = 1'b0, go = 1'b0;
    reg g1 = 1'b0, r1 = 1'b0, rp = 1'b0;
    reg [1:0] m1 = 2'h0, m2 = 2'h0;
    reg [15:0] ma1 = 16'h0003, mb1 = 16'h0002, ma2 = 16'h0003;
    reg [15:0] pm = 16'h0002;
    wire p1, p2, o1, o2, dma, slow, ptick;
    wire [15:0] c1, c2, c3;
    integer errors = 0, check_count = 0, i, k, nc, nd, nt, seed;
    always #10 mclk_in = ~mclk_in;
    ttpu_top ttpu_top_inst (
        .mclk_in(mclk_in), .reset_in(reset_in), .power_save_in(ps),
        .irq_event_in(irq), .first_mode_in(m1), .first_alt_in(a1),
        .first_ext_clk_in(e1), .first_src_in(s1), .first_gate_en_in(g1),
        .first_max_a_in(ma1), .first_max_b_in(mb1), .second_mode_in(m2),
        .second_alt_in(a2), .second_ext_clk_in(e2), .second_src_in(1'b0),
        .second_gate_en_in(1'b0), .second_max_a_in(ma2),
        .second_max_b_in(mb1), .prescale_en_in(pe), .prescale_max_in(pm),
        .first_restart_in(r1), .second_restart_in(1'b0),
        .prescale_restart_in(rp), .first_pin_timer_in(p1),
        .second_pin_timer_in(p2), .first_pin_timer_out(o1),
        .second_pin_timer_out(o2), .prescale_tick_out(ptick),
        .dma_request_out(dma), .slow_clock_out(slow),
        .first_count_out(c1), .second_count_out(c2),
        .prescale_count_out(c3));
    ttpu_event_src ttpu_event_src_inst (.mclk_in(mclk_in), .start_in(go),
        .pulses_in(8'h05), .pin_out(p1));
    ttpu_event_src ttpu_event_src_inst2 (.mclk_in(mclk_in), .start_in(go),
        .pulses_in(8'h07), .pin_out(p2));
    task step;
        begin
            @(posedge mclk_in);
            #2;
        end
    endtask
    task cmp(input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task complete_run;
        begin
            $display("checks=%0d errors=%0d", check_count, errors);
            if (errors == 0 && check_count > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask
    task restart_dut;
        begin
            reset_in = 1'b1;
            repeat (12) step;
            reset_in = 1'b0;
        end
    endtask
    // Model walks the count and the limit swap at every change
    task run_first(input integer w);
        integer j, prev, lim, low, due, n;
        begin
            prev = 0;
            lim = ma1;
            low = 0;
            due = 0;
            n = 0;
            for (j = 0; j < w; j = j + 1) begin
                step;
                if (c1 !== prev) begin
                    n = n + 1;
                    cmp(c1, (prev == lim) ? 0 : prev + 1);
                    if (prev == lim && a1) begin
                        low = 1 - low;
                        lim = low ? mb1 : ma1;
                        due = 3;
                    end
                    prev = c1;
                end
                if (due == 1)
                    cmp(o1, !low);
                if (due != 0)
                    due = due - 1;
            end
            cmp(n >= w / 4 - 1 && n <= w / 4 + 1, 1'b1);
            if (!a1)
                cmp(o1, 1'b1);
        end
    endtask
    task measure(input integer w);
        integer j;
        reg [15:0] last;
        reg last_t;
        begin
            nc = 0;
            nd = 0;
            nt = 0;
            last = c1;
            last_t = ptick;
            for (j = 0; j < w; j = j + 1) begin
                step;
                nc = nc + (c1 !== last);
                nd = nd + dma;
                nt = nt + (ptick && !last_t);
                last = c1;
                last_t = ptick;
                cmp(c3 <= pm, 1'b1);
            end
        end
    endtask
    initial begin
        seed = $urandom(32'h2aa0);
        restart_dut;
        cmp(o1 & o2, 1'b1);
        repeat (20) step;
        cmp({c1, c2}, 32'h0);
        for (k = 0; k < 2; k = k + 1) begin
            m1 = `TTPU_MODE_CONT;
            a1 = k[0];
            ma1 = 16'h0001 + $urandom % 6;
            mb1 = 16'h0001 + $urandom % 6;
            restart_dut;
            run_first(400);
        end
        a1 = 1'b0;
        m1 = `TTPU_MODE_SINGLE;
        m2 = `TTPU_MODE_SINGLE;
        restart_dut;
        repeat (100) step;
        cmp({o1, o2}, 2'h0);
        nc = c1;
        repeat (40) step;
        cmp(c1, nc);
        r1 = 1'b1;
        step;
        r1 = 1'b0;
        step;
        cmp(o1, 1'b1);
        repeat (40) step;
        cmp(o1, 1'b0);
        m1 = `TTPU_MODE_CONT;
        ma1 = 16'hffff;
        s1 = 1'b1;
        pe = 1'b1;
        restart_dut;
        measure(480);
        cmp(nc >= 39 && nc <= 41, 1'b1);
        cmp(nd >= 39 && nd <= 41, 1'b1);
        cmp(nt >= 39 && nt <= 41, 1'b1);
        rp = 1'b1;
        step;
        rp = 1'b0;
        step;
        cmp(c3, 16'h0000);
        s1 = 1'b0;
        pe = 1'b0;
        e1 = 1'b1;
        e2 = 1'b1;
        m2 = `TTPU_MODE_CONT;
        ma2 = 16'hffff;
        restart_dut;
        go = 1'b1;
        step;
        go = 1'b0;
        for (i = 0; i < 300 && c2 !== 16'h0007; i = i + 1)
            step;
        if (i == 300) begin
            errors = errors + 1;
            complete_run;
        end
        cmp({c1, c2}, {16'h0005, 16'h0007});
        e1 = 1'b0;
        g1 = 1'b1;
        restart_dut;
        repeat (40) step;
        cmp(c1 >= 9 && c1 <= 11, 1'b1);
        go = 1'b1;
        step;
        go = 1'b0;
        measure(40);
        cmp(nc >= 4 && nc <= 6, 1'b1);
        g1 = 1'b0;
        ps = 1'b1;
        restart_dut;
        repeat (4) step;
        cmp(slow, 1'b1);
        measure(640);
        cmp(nc >= 19 && nc <= 21, 1'b1);
        irq = 1'b1;
        repeat (2) step;
        cmp(slow, 1'b0);
        irq = 1'b0;
        complete_run;
    end
endmodule // tb_top
